//--- orme_core.sv
// Execute logic for OR-literal, OR-register, register copy, long call and long jump

module orme_core
    import orme_pkg::*;
(
    input  wire logic                    core_clk_in,
    input  wire logic                    resetn_in,
    input  wire logic [ORME_INSTR_W-1:0] instr_in,
    input  wire logic                    instr_valid_in,
    output logic [ORME_PC_W-1:0]         pc_out,
    output logic [ORME_DATA_W-1:0]       w_out,
    output logic                         zero_out,
    output logic                         stack_push_out,
    output logic [ORME_PC_W-1:0]         stack_top_out,
    output logic                         discard_out
);

    // Reset release synchroniser
    logic        rst_meta_q;
    logic        rst_sync_q;
    logic        rstn;

    // Architectural state
    logic [ORME_PC_W-1:0]   pc_q;
    logic [ORME_PC_W-1:0]   pc_d;
    logic [ORME_DATA_W-1:0] w_q;
    logic                   z_q;
    logic                   push_q;
    logic [ORME_PC_W-1:0]   stack_top_q;
    orme_state_t            state_q;

    // Decode results
    orme_cls_t               cls;
    logic                    take;
    logic                    dest_file;
    logic [ORME_FADDR_W-1:0] faddr;
    logic [ORME_PC_W-1:0]    target;
    logic [ORME_DATA_W-1:0]  literal;
    logic [ORME_DATA_W-1:0]  result;
    logic                    writes_result;

    orme_rf_if rf ();

    // Classify one opcode word
    function automatic orme_cls_t decode_class(input logic [ORME_INSTR_W-1:0] op);
        orme_cls_t c;
        c = ORME_CLS_OTHER;
        if (op[ORME_INSTR_W-1:ORME_SEL_LSB] == ORME_OPC_OR_LIT) begin
            c = ORME_CLS_OR_LIT;
        end else if (op[ORME_SEL_MSB:ORME_SEL_LSB] == ORME_SEL_OR_REG) begin
            c = ORME_CLS_OR_REG;
        end else if (op[ORME_SEL_MSB:ORME_SEL_LSB] == ORME_SEL_COPY) begin
            c = ORME_CLS_COPY;
        end else if (op[ORME_BR_MSB:ORME_BR_LSB] == ORME_BR_CALL) begin
            c = ORME_CLS_CALL;
        end else if (op[ORME_BR_MSB:ORME_BR_LSB] == ORME_BR_JUMP) begin
            c = ORME_CLS_JUMP;
        end
        return c;
    endfunction

    // Zero test of an 8-bit result
    function automatic logic is_zero(input logic [ORME_DATA_W-1:0] v);
        return (v == '0);
    endfunction

    // Asynchronous assert, synchronous release of reset
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rstn = rst_sync_q;

    // Field extraction; opcode and rf come from logic on this clock
    always_comb begin
        cls       = decode_class(instr_in);
        take      = instr_valid_in && (state_q == ORME_ST_EXEC);
        dest_file = instr_in[ORME_D_BIT];
        faddr     = {instr_in[ORME_HI_MSB:ORME_HI_LSB], instr_in[ORME_FLO_MSB:0]};
        target    = {instr_in[ORME_HI_MSB:ORME_HI_LSB], instr_in[ORME_KLO_MSB:0]};
        literal   = instr_in[ORME_DATA_W-1:0];
    end

    // ALU result for the three single-cycle operations
    always_comb begin
        result        = rf.rd_data;
        writes_result = 1'b0;
        unique case (cls)
            ORME_CLS_OR_LIT: begin
                result        = w_q | literal;
                writes_result = 1'b1;
            end
            ORME_CLS_OR_REG: begin
                result        = w_q | rf.rd_data;
                writes_result = 1'b1;
            end
            ORME_CLS_COPY: begin
                result        = rf.rd_data;
                writes_result = 1'b1;
            end
            ORME_CLS_CALL,
            ORME_CLS_JUMP,
            ORME_CLS_OTHER: begin
                result        = rf.rd_data;
                writes_result = 1'b0;
            end
        endcase
    end

    // Register file port: copy with d=1 rewrites the same value, harmless
    assign rf.rd_addr = faddr;
    assign rf.wr_addr = faddr;
    assign rf.wr_data = result;
    assign rf.wr_en   = take && writes_result && dest_file
                        && (cls != ORME_CLS_OR_LIT);

    orme_regfile u_regfile (
        .clk_in (core_clk_in),
        .rf     (rf)
    );

    // Working register: literal OR always lands here, register ops when d=0
    always_ff @(posedge core_clk_in or negedge rstn) begin
        if (!rstn) begin
            w_q <= ORME_W_RST;
        end else if (take && writes_result) begin
            if (cls == ORME_CLS_OR_LIT || !dest_file) begin
                w_q <= result;
            end
        end
    end

    // Zero flag follows every result; branches leave it alone
    always_ff @(posedge core_clk_in or negedge rstn) begin
        if (!rstn) begin
            z_q <= ORME_Z_RST;
        end else if (take && writes_result) begin
            z_q <= is_zero(result);
        end
    end

    // Next program counter
    always_comb begin
        pc_d = pc_q;
        if (take) begin
            unique case (cls)
                ORME_CLS_CALL,
                ORME_CLS_JUMP: begin
                    pc_d = target;
                end
                ORME_CLS_OR_LIT,
                ORME_CLS_OR_REG,
                ORME_CLS_COPY,
                ORME_CLS_OTHER: begin
                    pc_d = pc_q + 13'h0001;
                end
            endcase
        end
    end

    // Program counter; held through the discarded slot
    always_ff @(posedge core_clk_in or negedge rstn) begin
        if (!rstn) begin
            pc_q <= ORME_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // Return stack push: only the call, never the jump
    always_ff @(posedge core_clk_in or negedge rstn) begin
        if (!rstn) begin
            push_q      <= 1'b0;
            stack_top_q <= ORME_PC_RST;
        end else begin
            push_q <= take && (cls == ORME_CLS_CALL);
            if (take && cls == ORME_CLS_CALL) begin
                stack_top_q <= pc_q + 13'h0001;
            end
        end
    end

    // Second cycle of a branch throws away the word fetched behind it
    always_ff @(posedge core_clk_in or negedge rstn) begin
        if (!rstn) begin
            state_q <= ORME_ST_EXEC;
        end else begin
            unique case (state_q)
                ORME_ST_EXEC: begin
                    if (take && (cls == ORME_CLS_CALL || cls == ORME_CLS_JUMP)) begin
                        state_q <= ORME_ST_DISCARD;
                    end
                end
                ORME_ST_DISCARD: begin
                    if (instr_valid_in) begin
                        state_q <= ORME_ST_EXEC;
                    end
                end
            endcase
        end
    end

    // All outputs straight from flops
    assign pc_out         = pc_q;
    assign w_out          = w_q;
    assign zero_out       = z_q;
    assign stack_push_out = push_q;
    assign stack_top_out  = stack_top_q;
    assign discard_out    = (state_q == ORME_ST_DISCARD);

endmodule

//--- orme_core_checker.sv
// Port-level assertions for the OR, copy and long-branch execute block
module orme_core_checker
    import orme_pkg::*;
(
    input wire logic                    core_clk_in,
    input wire logic                    resetn_in,
    input wire logic [ORME_INSTR_W-1:0] instr_in,
    input wire logic                    instr_valid_in,
    input wire logic [ORME_PC_W-1:0]    pc_out,
    input wire logic [ORME_DATA_W-1:0]  w_out,
    input wire logic                    zero_out,
    input wire logic                    stack_push_out,
    input wire logic [ORME_PC_W-1:0]    stack_top_out,
    input wire logic                    discard_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);
    logic tk, lit, call, brc, rop;
    // Decode of taken words; the literal OR wins over the branch field
    assign tk   = instr_valid_in && !discard_out;
    assign lit  = tk && instr_in[15:8] == ORME_OPC_OR_LIT;
    assign call = tk && !lit && instr_in[13:11] == ORME_BR_CALL;
    assign brc  = call || (tk && !lit && instr_in[13:11] == ORME_BR_JUMP);
    assign rop  = tk && (instr_in[13:8] == ORME_SEL_OR_REG || instr_in[13:8] == ORME_SEL_COPY);

    a_lit_result: assert property (lit |=>
        w_out == ($past(w_out) | $past(instr_in[7:0])) && zero_out == (w_out == 8'h00))
        else $error("literal OR result wrong");
    a_single_cycle: assert property (tk && !brc |=>
        !discard_out && pc_out == $past(pc_out) + 13'h1)
        else $error("one-cycle op did not advance");
    a_push_pulse: assert property (call |=>
        stack_push_out && stack_top_out == $past(pc_out) + 13'h1 ##1 !stack_push_out)
        else $error("call push wrong");
    a_push_cause: assert property (stack_push_out |-> $past(call))
        else $error("push without call");
    a_branch_target: assert property (brc |=>
        discard_out && pc_out == {$past(instr_in[15:14]), $past(instr_in[10:0])}
        && $stable(w_out) && $stable(zero_out))
        else $error("branch target or flags wrong");
    a_jump_no_push: assert property (brc && !call |=> !stack_push_out)
        else $error("jump touched stack");
    a_discard_wait: assert property (discard_out && !instr_valid_in |=>
        discard_out && $stable(pc_out))
        else $error("discard slot left early");
    a_discard_swallow: assert property (discard_out && instr_valid_in |=>
        !discard_out && $stable(pc_out) && $stable(w_out) && $stable(zero_out))
        else $error("discarded word had effect");
    a_reg_to_w: assert property (rop && !instr_in[7] |=>
        zero_out == (w_out == 8'h00))
        else $error("zero flag not from W result");
    a_reg_keep_w: assert property (rop && instr_in[7] |=> $stable(w_out))
        else $error("W changed on file write-back");
endmodule

//--- orme_core_test.sv
// Self-checking bench for the execute block
module orme_core_test import orme_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, resetn, vld, z, push, disc;
    logic [12:0] pc, top, ep;
    logic [15:0] ins;
    logic [7:0]  w;
    int          failures, samples_checked;

    orme_core dut (.core_clk_in(clk), .resetn_in(resetn), .instr_in(ins),
        .instr_valid_in(vld), .pc_out(pc), .w_out(w), .zero_out(z),
        .stack_push_out(push), .stack_top_out(top), .discard_out(disc));
    orme_prog_model pm (.pc_in(pc), .valid_in(vld), .instr_out(ins));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Hold valid for n taking edges
    task automatic go(input int n);
        @(posedge clk) vld <= 1'b1;
        repeat (n) @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask
    // Three edges after release before the first word
    task automatic do_reset();
        @(posedge clk) resetn <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        ep = 13'h0000;
    endtask
    task automatic t_lit();
        chk("pc", 0, pc);
        chk("w", 0, w);
        pm.mem[ep] = 16'h1a00;
        go(1);
        chk("z", 1, z);
        pm.mem[ep+1] = 16'h1a9a;
        pm.mem[ep+2] = 16'h1a35;
        go(2);
        ep = ep + 3;
        chk("w", 16'hbf, w);
        chk("z", 0, z);
        chk("pc", ep, pc);
    endtask
    task automatic t_jump();
        pm.mem[ep] = 16'heabc;
        pm.mem[13'h1abc] = 16'h1a40;
        go(1);
        chk("pc", 16'h1abc, pc);
        chk("disc", 1, disc);
        chk("push", 0, push);
        repeat (2) @(posedge clk);
        #1;
        chk("disc", 1, disc);
        go(1);
        chk("disc", 0, disc);
        chk("w", 16'hbf, w);
        go(1);
        chk("w", 16'hff, w);
        ep = 13'h1abd;
        chk("pc", ep, pc);
    endtask
    task automatic t_call();
        pm.mem[ep] = 16'he7ff;
        pm.mem[13'h1fff] = 16'h1aff;
        pm.mem[13'h0000] = 16'hc4a5;
        go(1);
        chk("push", 1, push);
        chk("top", ep + 13'h1, top);
        chk("pc", 16'h1fff, pc);
        @(posedge clk);
        #1;
        chk("push", 0, push);
        go(3);
        chk("pc", 1, pc);
        chk("w", 16'hff, w);
    endtask
    task automatic t_copy();
        do_reset();
        pm.mem[0] = 16'h1a00;
        pm.mem[1] = 16'hc8a5;
        go(2);
        chk("w", 0, w);
        chk("z", 0, z);
        pm.mem[2] = 16'hc825;
        go(1);
        chk("w", 16'hff, w);
        do_reset();
        // W starts at zero so a write-back that leaked into W would show
        pm.mem[1] = 16'hc4a5;
        pm.mem[2] = 16'hc425;
        go(2);
        chk("w", 16'h00, w);
        chk("z", 16'h00, z);
        go(1);
        chk("w", 16'hff, w);
        chk("z", 16'h00, z);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        resetn = 1'b0;
        vld = 1'b0;
        do_reset();
        t_lit();
        t_jump();
        t_call();
        t_copy();
        report_and_stop();
    end
    // Watchdog well beyond the fewer than one hundred cycles needed
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule

bind orme_core orme_core_checker chk_i (.core_clk_in, .resetn_in, .instr_in,
    .instr_valid_in, .pc_out, .w_out, .zero_out, .stack_push_out,
    .stack_top_out, .discard_out);

//--- orme_pkg.sv
// Shared constants and types for the OR, move and long-branch execute block
package orme_pkg;

    // Widths
    localparam int ORME_INSTR_W  = 16;
    localparam int ORME_DATA_W   = 8;
    localparam int ORME_FADDR_W  = 9;
    localparam int ORME_PC_W     = 13;
    localparam int ORME_RF_DEPTH = 512;

    // Opcode field positions
    localparam int ORME_HI_MSB   = 15;
    localparam int ORME_HI_LSB   = 14;
    localparam int ORME_D_BIT    = 7;
    localparam int ORME_FLO_MSB  = 6;
    localparam int ORME_KLO_MSB  = 10;
    localparam int ORME_SEL_MSB  = 13;
    localparam int ORME_SEL_LSB  = 8;
    localparam int ORME_BR_MSB   = 13;
    localparam int ORME_BR_LSB   = 11;

    // Opcode match values
    localparam logic [7:0] ORME_OPC_OR_LIT   = 8'h1a;
    localparam logic [5:0] ORME_SEL_OR_REG   = 6'h04;
    localparam logic [5:0] ORME_SEL_COPY     = 6'h08;
    localparam logic [2:0] ORME_BR_CALL      = 3'h4;
    localparam logic [2:0] ORME_BR_JUMP      = 3'h5;

    // Reset values
    localparam logic [ORME_PC_W-1:0]   ORME_PC_RST = 13'h0000;
    localparam logic [ORME_DATA_W-1:0] ORME_W_RST  = 8'h00;
    localparam logic                   ORME_Z_RST  = 1'b0;

    // Instruction classes handled here; everything else just advances
    typedef enum logic [2:0] {
        ORME_CLS_OR_LIT,
        ORME_CLS_OR_REG,
        ORME_CLS_COPY,
        ORME_CLS_CALL,
        ORME_CLS_JUMP,
        ORME_CLS_OTHER
    } orme_cls_t;

    // Execute slot state
    typedef enum logic {
        ORME_ST_EXEC,
        ORME_ST_DISCARD
    } orme_state_t;

endpackage

//--- orme_prog_model.sv
// Program memory model answering the program counter with opcode words
module orme_prog_model
    import orme_pkg::*;
(
    input  wire logic [ORME_PC_W-1:0]    pc_in,
    input  wire logic                    valid_in,
    output logic      [ORME_INSTR_W-1:0] instr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ORME_INSTR_W-1:0] mem [2**ORME_PC_W];
    // Empty memory reads as no-operation words
    initial begin
        for (int i = 0; i < 2**ORME_PC_W; i++) mem[i] = 16'h0000;
    end
    // Invalid cycles show a mangled word so stale data is never trusted
    assign instr_out = valid_in ? mem[pc_in] : ~mem[pc_in];
endmodule

//--- orme_regfile.sv
// Data register file: 512 bytes, combinational read, clocked write
module orme_regfile
    import orme_pkg::*;
(
    input  wire logic clk_in,
    orme_rf_if.file   rf
);

    logic [ORME_DATA_W-1:0] mem_q [ORME_RF_DEPTH];

    // Read is combinational so a single-cycle read-modify-write fits one slot
    assign rf.rd_data = mem_q[rf.rd_addr];

    // Write port; contents are data, so no reset
    always_ff @(posedge clk_in) begin
        if (rf.wr_en) begin
            mem_q[rf.wr_addr] <= rf.wr_data;
        end
    end

endmodule

//--- orme_rf_if.sv
// Data register file access bundle between the execute core and the file
interface orme_rf_if;
    import orme_pkg::*;

    logic [ORME_FADDR_W-1:0] rd_addr;
    logic [ORME_DATA_W-1:0]  rd_data;
    logic                    wr_en;
    logic [ORME_FADDR_W-1:0] wr_addr;
    logic [ORME_DATA_W-1:0]  wr_data;

    modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
    modport file (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface
